// file: fsia_pkg.sv
// fsia_pkg: constants of the fourteen-source interrupt arbiter
// How it works
// - port flag register at C0, bit0 is port 2
// - same-level requests served in fixed polling order
// - fixed vectors for ext0, timers, ext1, serial
// - port interrupts vector from 003B, eight apart
// - receive or transmit done raise one serial request
// - timer2 overflow or external flag share one request
// - reset clears flag, enable, priority, polarity registers
// - hardware sets port flags, only software clears
// - flag still set at return requests again
// - port requests level sensitive, per-bit polarity
// - per-source enable, global enable, two priority levels
`default_nettype none
package fsia_pkg;
	localparam int SRC_NUM = 14;
	localparam int PORT_NUM = 8;
	localparam int POS_W = 4;
	// register map
	localparam logic [7:0] ADDR_PORT_FLAGS = 8'hc0;
	localparam logic [7:0] ADDR_EVT_STAT = 8'hc1;
	localparam logic [7:0] ADDR_EVT_MASK = 8'hc2;
	localparam logic [7:0] ADDR_SVC = 8'hc3;
	localparam logic [7:0] ADDR_ENABLE_A = 8'ha8;
	localparam logic [7:0] ADDR_ENABLE_B = 8'he8;
	localparam logic [7:0] ADDR_PRI_A = 8'hb8;
	localparam logic [7:0] ADDR_PRI_B = 8'hf8;
	localparam logic [7:0] ADDR_POLARITY = 8'he9;
	localparam logic [7:0] REG_RESET = 8'h00;
	// fields of enable_a and priority_level_reg_a, EN_GLOBAL of enable_a only
	localparam int EN_GLOBAL = 7;
	localparam int EN_T2 = 5;
	localparam int EN_SER = 4;
	localparam int EN_T1 = 3;
	localparam int EN_X1 = 2;
	localparam int EN_T0 = 1;
	localparam int EN_X0 = 0;
	// event status bits
	localparam int EVT_TAKEN = 0;
	localparam int EVT_PORT_SET = 1;
	localparam int EVT_RETRIGGER = 2;
	// polling positions, 0 served first
	localparam logic [3:0] POS_X0 = 4'h0;
	localparam logic [3:0] POS_SER = 4'h1;
	localparam logic [3:0] POS_T0 = 4'h3;
	localparam logic [3:0] POS_X1 = 4'h5;
	localparam logic [3:0] POS_T1 = 4'h8;
	localparam logic [3:0] POS_T2 = 4'h9;
	// ports 9 down to 2
	localparam logic [7:0][3:0] PORT_POS = {4'hd, 4'hb, 4'h7, 4'h4, 4'h2, 4'hc, 4'ha, 4'h6};
	// vector addresses
	localparam logic [15:0] VEC_X0 = 16'h0003;
	localparam logic [15:0] VEC_T0 = 16'h000b;
	localparam logic [15:0] VEC_X1 = 16'h0013;
	localparam logic [15:0] VEC_T1 = 16'h001b;
	localparam logic [15:0] VEC_SER = 16'h0023;
	localparam logic [15:0] VEC_T2 = 16'h002b;
	localparam logic [15:0] VEC_PORT_BASE = 16'h003b;
	localparam logic [15:0] VEC_PORT_STEP = 16'h0008;
	localparam logic [15:0] VEC_PORT_LAST = 16'h0073;
endpackage
`default_nettype wire

// file: fsia_poll_sel.sv
// fsia_poll_sel: two-level fixed-order request selector
`default_nettype none
module fsia_poll_sel #(
	parameter int NUM_SRC = 14,
	parameter int IDX_W = 4
) (
	// requests in polling order, bit 0 first
	input wire logic [NUM_SRC-1:0] req,
	input wire logic [NUM_SRC-1:0] hi,
	// level gates
	input wire logic allow_hi,
	input wire logic allow_lo,
	// choice
	output logic valid,
	output logic [IDX_W-1:0] idx,
	output logic level
);
	if (NUM_SRC < 1 || NUM_SRC > (1 << IDX_W))
	begin : g_bad
		$error("fsia_poll_sel: NUM_SRC does not fit IDX_W");
	end

	function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] c);
		logic [IDX_W-1:0] r;
		r = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (c[i])
				r = IDX_W'(i);
		end
		return r;
	endfunction

	logic [NUM_SRC-1:0] cand_hi;
	logic [NUM_SRC-1:0] cand_lo;

	always_comb
	begin
		cand_hi = req & hi;
		cand_lo = req & ~hi;
		valid = 1'b0;
		idx = '0;
		level = 1'b0;
		// a high request that is only gated does not hold back a low one
		if (allow_hi && |cand_hi)
		begin
			valid = 1'b1;
			level = 1'b1;
			idx = first_set(cand_hi);
		end
		else if (allow_lo && |cand_lo)
		begin
			valid = 1'b1;
			idx = first_set(cand_lo);
		end
	end
endmodule
`default_nettype wire

// file: fsia_port_flags.sv
// fsia_port_flags: level-sensitive port request flags
`default_nettype none
module fsia_port_flags #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pins and polarity
	input wire logic [WIDTH-1:0] port_pins,
	input wire logic [WIDTH-1:0] polarity,
	// software write
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wdata,
	// flags
	output logic [WIDTH-1:0] flags,
	output logic set_evt
);
	if (WIDTH < 1 || WIDTH > 8)
	begin : g_bad
		$error("fsia_port_flags: WIDTH must be 1 to 8");
	end

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} fsia_flag_state_t;

	fsia_flag_state_t st;
	fsia_flag_state_t nxt;
	logic [WIDTH-1:0] active;

	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		// polarity 1: high pin requests, 0: low pin requests
		assign active[i] = ~(port_pins[i] ^ polarity[i]);
	end

	always_comb
	begin
		nxt = st;
		if (wr_en)
			nxt.flags = wdata;
		// the pin level wins over a clearing write
		nxt.flags = nxt.flags | active;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= nxt;
	end

	assign flags = st.flags;
	assign set_evt = |(active & ~st.flags);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	flag_holds_a: assert property (
		!wr_en |=> (flags & $past(flags)) == $past(flags))
		else $error("port flag dropped without a write");
	flag_sets_a: assert property (
		1'b1 |=> (flags & ~($past(port_pins) ^ $past(polarity))) ==
			~($past(port_pins) ^ $past(polarity)))
		else $error("active port level did not set its flag");
endmodule
`default_nettype wire

// file: fsia_arbiter.sv
// fsia_arbiter: fourteen-source two-level interrupt arbiter with register port
`default_nettype none
module fsia_arbiter #(
	parameter int PORT_NUM = fsia_pkg::PORT_NUM
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// peripheral flags
	input wire logic ext0_request_flag,
	input wire logic ext1_request_flag,
	input wire logic timer0_overflow_flag,
	input wire logic timer1_overflow_flag,
	input wire logic timer2_overflow_flag,
	input wire logic timer2_external_flag,
	input wire logic serial_receive_done,
	input wire logic serial_transmit_done,
	// port interrupt pins 2 to 9
	input wire logic [PORT_NUM-1:0] port_pins,
	// processor core
	output logic core_irq_req,
	output logic [15:0] core_irq_vec,
	output logic core_irq_level,
	input wire logic core_irq_ack,
	input wire logic core_irq_ret,
	// hardware clear of edge flags
	output logic ext0_taken,
	output logic ext1_taken,
	output logic timer0_taken,
	output logic timer1_taken,
	// event interrupt
	output logic irq_o
);
	if (PORT_NUM != 8)
	begin : g_bad
		$error("fsia_arbiter: layout needs exactly eight port interrupts");
	end

	typedef struct packed {
		logic [7:0] enable_a;
		logic [7:0] enable_b;
		logic [7:0] priority_level_reg_a;
		logic [7:0] priority_level_reg_b;
		logic [7:0] port_irq_polarity_reg;
		logic [7:0] evt_status;
		logic [7:0] evt_mask;
		logic [7:0] rdata;
		logic [1:0] in_svc;
		logic req;
		logic level;
		logic [fsia_pkg::POS_W-1:0] pos;
		logic [15:0] vec;
		logic taken;
		logic [fsia_pkg::POS_W-1:0] taken_pos;
	} fsia_core_state_t;

	fsia_core_state_t st;
	fsia_core_state_t nxt;

	logic [PORT_NUM-1:0] port_flags;
	logic flag_set_evt;
	logic flag_wr;
	logic [fsia_pkg::SRC_NUM-1:0] req_en;
	logic [fsia_pkg::SRC_NUM-1:0] pri_hi;
	logic [fsia_pkg::SRC_NUM-1:0] cand;
	logic global_irq_enable;
	logic serial_req;
	logic timer2_req;
	logic allow_hi;
	logic allow_lo;
	logic sel_valid;
	logic [fsia_pkg::POS_W-1:0] sel_idx;
	logic sel_level;
	logic ack_ok;

	function automatic logic [15:0] vec_of(input logic [fsia_pkg::POS_W-1:0] pos);
		logic [15:0] v;
		v = fsia_pkg::VEC_X0;
		case (pos)
			fsia_pkg::POS_X0: v = fsia_pkg::VEC_X0;
			fsia_pkg::POS_SER: v = fsia_pkg::VEC_SER;
			fsia_pkg::POS_T0: v = fsia_pkg::VEC_T0;
			fsia_pkg::POS_X1: v = fsia_pkg::VEC_X1;
			fsia_pkg::POS_T1: v = fsia_pkg::VEC_T1;
			fsia_pkg::POS_T2: v = fsia_pkg::VEC_T2;
			default:
			begin
				for (int n = 0; n < PORT_NUM; n++)
				begin
					if (pos == fsia_pkg::PORT_POS[n])
						v = fsia_pkg::VEC_PORT_BASE + 16'(n) * fsia_pkg::VEC_PORT_STEP;
				end
			end
		endcase
		return v;
	endfunction

	assign flag_wr = reg_wr && reg_addr == fsia_pkg::ADDR_PORT_FLAGS;

	fsia_port_flags #(
		.WIDTH(PORT_NUM)
	) u_flags (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.port_pins(port_pins),
		.polarity(st.port_irq_polarity_reg),
		.wr_en(flag_wr),
		.wdata(reg_wdata),
		.flags(port_flags),
		.set_evt(flag_set_evt)
	);

	// request and priority vectors in polling order
	always_comb
	begin
		global_irq_enable = st.enable_a[fsia_pkg::EN_GLOBAL];
		serial_req = serial_receive_done | serial_transmit_done;
		timer2_req = timer2_overflow_flag | timer2_external_flag;
		req_en = '0;
		pri_hi = '0;
		req_en[fsia_pkg::POS_X0] = ext0_request_flag & st.enable_a[fsia_pkg::EN_X0];
		req_en[fsia_pkg::POS_SER] = serial_req & st.enable_a[fsia_pkg::EN_SER];
		req_en[fsia_pkg::POS_T0] = timer0_overflow_flag & st.enable_a[fsia_pkg::EN_T0];
		req_en[fsia_pkg::POS_X1] = ext1_request_flag & st.enable_a[fsia_pkg::EN_X1];
		req_en[fsia_pkg::POS_T1] = timer1_overflow_flag & st.enable_a[fsia_pkg::EN_T1];
		req_en[fsia_pkg::POS_T2] = timer2_req & st.enable_a[fsia_pkg::EN_T2];
		pri_hi[fsia_pkg::POS_X0] = st.priority_level_reg_a[fsia_pkg::EN_X0];
		pri_hi[fsia_pkg::POS_SER] = st.priority_level_reg_a[fsia_pkg::EN_SER];
		pri_hi[fsia_pkg::POS_T0] = st.priority_level_reg_a[fsia_pkg::EN_T0];
		pri_hi[fsia_pkg::POS_X1] = st.priority_level_reg_a[fsia_pkg::EN_X1];
		pri_hi[fsia_pkg::POS_T1] = st.priority_level_reg_a[fsia_pkg::EN_T1];
		pri_hi[fsia_pkg::POS_T2] = st.priority_level_reg_a[fsia_pkg::EN_T2];
		// a flag left set keeps requesting after return
		for (int n = 0; n < PORT_NUM; n++)
		begin
			req_en[fsia_pkg::PORT_POS[n]] = port_flags[n] & st.enable_b[n];
			pri_hi[fsia_pkg::PORT_POS[n]] = st.priority_level_reg_b[n];
		end
		// a high routine blocks all, a low routine blocks its own level
		allow_hi = global_irq_enable && !st.in_svc[1];
		allow_lo = global_irq_enable && st.in_svc == 2'b00;
	end

	fsia_poll_sel #(
		.NUM_SRC(fsia_pkg::SRC_NUM),
		.IDX_W(fsia_pkg::POS_W)
	) u_sel (
		.req(req_en),
		.hi(pri_hi),
		.allow_hi(allow_hi),
		.allow_lo(allow_lo),
		.valid(sel_valid),
		.idx(sel_idx),
		.level(sel_level)
	);

	assign ack_ok = core_irq_ack && st.req;

	always_comb
	begin
		nxt = st;
		nxt.taken = 1'b0;
		nxt.rdata = '0;
		if (reg_wr)
		begin
			case (reg_addr)
				fsia_pkg::ADDR_ENABLE_A: nxt.enable_a = reg_wdata;
				fsia_pkg::ADDR_ENABLE_B: nxt.enable_b = reg_wdata;
				fsia_pkg::ADDR_PRI_A: nxt.priority_level_reg_a = reg_wdata;
				fsia_pkg::ADDR_PRI_B: nxt.priority_level_reg_b = reg_wdata;
				fsia_pkg::ADDR_POLARITY: nxt.port_irq_polarity_reg = reg_wdata;
				fsia_pkg::ADDR_EVT_STAT: nxt.evt_status = st.evt_status & ~reg_wdata;
				fsia_pkg::ADDR_EVT_MASK: nxt.evt_mask = reg_wdata;
				default: nxt.evt_mask = st.evt_mask;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				fsia_pkg::ADDR_PORT_FLAGS: nxt.rdata = port_flags;
				fsia_pkg::ADDR_ENABLE_A: nxt.rdata = st.enable_a;
				fsia_pkg::ADDR_ENABLE_B: nxt.rdata = st.enable_b;
				fsia_pkg::ADDR_PRI_A: nxt.rdata = st.priority_level_reg_a;
				fsia_pkg::ADDR_PRI_B: nxt.rdata = st.priority_level_reg_b;
				fsia_pkg::ADDR_POLARITY: nxt.rdata = st.port_irq_polarity_reg;
				fsia_pkg::ADDR_EVT_STAT: nxt.rdata = st.evt_status;
				fsia_pkg::ADDR_EVT_MASK: nxt.rdata = st.evt_mask;
				fsia_pkg::ADDR_SVC: nxt.rdata = {6'h00, st.in_svc};
				default: nxt.rdata = '0;
			endcase
		end
		// return ends the newest routine, a higher one if two are nested
		if (core_irq_ret)
		begin
			if (st.in_svc[1])
				nxt.in_svc[1] = 1'b0;
			else
				nxt.in_svc[0] = 1'b0;
			if (global_irq_enable && |(port_flags & st.enable_b))
				nxt.evt_status[fsia_pkg::EVT_RETRIGGER] = 1'b1;
		end
		if (ack_ok)
		begin
			nxt.in_svc[st.level] = 1'b1;
			nxt.taken = 1'b1;
			nxt.taken_pos = st.pos;
			nxt.evt_status[fsia_pkg::EVT_TAKEN] = 1'b1;
		end
		if (flag_set_evt)
			nxt.evt_status[fsia_pkg::EVT_PORT_SET] = 1'b1;
		// dropped for the cycle after an ack so the same choice is not offered twice
		nxt.req = sel_valid && !ack_ok;
		nxt.level = sel_level;
		nxt.pos = sel_idx;
		nxt.vec = vec_of(sel_idx);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= nxt;
	end

	assign reg_rdata = st.rdata;
	assign core_irq_req = st.req;
	assign core_irq_vec = st.vec;
	assign core_irq_level = st.level;
	assign ext0_taken = st.taken && st.taken_pos == fsia_pkg::POS_X0;
	assign ext1_taken = st.taken && st.taken_pos == fsia_pkg::POS_X1;
	assign timer0_taken = st.taken && st.taken_pos == fsia_pkg::POS_T0;
	assign timer1_taken = st.taken && st.taken_pos == fsia_pkg::POS_T1;
	assign irq_o = |(st.evt_status & st.evt_mask);

	// candidates of the chosen level, only read by the checks below
	assign cand = sel_level ? (req_en & pri_hi) : (req_en & ~pri_hi);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	flag_readback_a: assert property (
		reg_rd && reg_addr == fsia_pkg::ADDR_PORT_FLAGS |=> reg_rdata == $past(port_flags))
		else $error("port flag register read wrong");
	poll_order_a: assert property (
		sel_valid |-> cand[sel_idx] &&
			(cand & ((14'h0001 << sel_idx) - 14'h0001)) == 14'h0000)
		else $error("earlier same-level request was skipped");
	fixed_vector_a: assert property (
		core_irq_req && core_irq_vec == fsia_pkg::VEC_X0 |-> $past(ext0_request_flag))
		else $error("ext0 vector without ext0 request");
	port_vector_a: assert property (
		core_irq_req |-> core_irq_vec[2:0] == 3'h3 &&
			core_irq_vec <= fsia_pkg::VEC_PORT_LAST)
		else $error("vector outside the fixed table");
	serial_merge_a: assert property (
		(serial_receive_done || serial_transmit_done) && global_irq_enable &&
			st.enable_a[fsia_pkg::EN_SER] && st.in_svc == 2'b00 && !ack_ok
			|=> core_irq_req)
		else $error("serial request not raised");
	timer2_merge_a: assert property (
		(timer2_overflow_flag || timer2_external_flag) && global_irq_enable &&
			st.enable_a[fsia_pkg::EN_T2] && st.in_svc == 2'b00 && !ack_ok
			|=> core_irq_req)
		else $error("timer2 request not raised");
	reset_clear_a: assert property (
		$fell(sys_rst) |-> st.enable_a == fsia_pkg::REG_RESET &&
			st.enable_b == fsia_pkg::REG_RESET &&
			st.priority_level_reg_a == fsia_pkg::REG_RESET &&
			st.priority_level_reg_b == fsia_pkg::REG_RESET &&
			st.port_irq_polarity_reg == fsia_pkg::REG_RESET)
		else $error("registers not cleared by reset");
	retrigger_flag_a: assert property (
		core_irq_ret && global_irq_enable && |(port_flags & st.enable_b)
			|=> st.evt_status[fsia_pkg::EVT_RETRIGGER])
		else $error("return with pending port flag not noted");
	global_gate_a: assert property (
		!global_irq_enable |=> !core_irq_req)
		else $error("request offered while globally disabled");
	high_first_a: assert property (
		sel_valid && allow_hi && |(req_en & pri_hi) |-> sel_level)
		else $error("low level chosen over a high one");
	ack_one_shot_a: assert property (
		ack_ok |=> !core_irq_req ##1 (st.in_svc != 2'b00))
		else $error("request not withdrawn after acknowledge");
endmodule
`default_nettype wire

// file: fsia_core_model.sv
// fsia_core_model: processor core that takes offered vectors and returns later
`default_nettype none
module fsia_core_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// offer from arbiter
	input wire logic core_irq_req,
	input wire logic [15:0] core_irq_vec,
	input wire logic core_irq_level,
	output logic core_irq_ack,
	output logic core_irq_ret,
	// bench control
	input wire logic arm,
	input wire logic [7:0] ack_dly,
	input wire logic [7:0] svc_len,
	// observation
	output logic [15:0] last_vec,
	output logic last_lvl,
	output logic [7:0] n_taken,
	output logic busy
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt;
	// no nesting: the offer must settle for ack_dly cycles before it is taken
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			core_irq_ack <= 1'b0;
			core_irq_ret <= 1'b0;
			last_vec <= 16'h0000;
			last_lvl <= 1'b0;
			n_taken <= 8'h00;
			busy <= 1'b0;
			cnt <= 8'h00;
		end
		else
		begin
			core_irq_ret <= 1'b0;
			core_irq_ack <= 1'b0;
			// an ack that meets no offer is ignored by the arbiter, so not counted here
			if (core_irq_ack && core_irq_req)
			begin
				last_vec <= core_irq_vec;
				last_lvl <= core_irq_level;
				n_taken <= n_taken + 8'h01;
				busy <= 1'b1;
				cnt <= svc_len;
			end
			else if (busy)
			begin
				if (cnt == 8'h00)
				begin
					core_irq_ret <= 1'b1;
					busy <= 1'b0;
				end
				else
					cnt <= cnt - 8'h01;
			end
			else if (arm && core_irq_req)
			begin
				if (cnt >= ack_dly)
					core_irq_ack <= 1'b1;
				else
					cnt <= cnt + 8'h01;
			end
			else
				cnt <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// file: test_fourteen_source_interrupt_arbiter.sv
// test_fourteen_source_interrupt_arbiter: register and arbitration tests
`default_nettype none
`define CHECK(nm, e, g) \
	begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s: expected %h seen %h", nm, e, g); end end
module test_fourteen_source_interrupt_arbiter;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0, sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic ext0_request_flag = 1'b0, ext1_request_flag = 1'b0;
	logic timer0_overflow_flag = 1'b0, timer1_overflow_flag = 1'b0;
	logic timer2_overflow_flag = 1'b0, timer2_external_flag = 1'b0;
	logic serial_receive_done = 1'b0, serial_transmit_done = 1'b0;
	logic [7:0] port_pins = 8'hff;
	logic core_irq_req, core_irq_level, core_irq_ack, core_irq_ret, irq_o;
	logic [15:0] core_irq_vec, last_vec;
	logic last_lvl, busy;
	logic [7:0] n_taken;
	logic [3:0] tk;
	int n_tk [4] = '{0, 0, 0, 0};
	int n_mismatch = 0, total_checks = 0, cycles = 0;
	// port 9 is raised to the high level, so it leads; the rest follow polling order
	localparam logic [15:0] ORDER [14] = '{16'h0073, 16'h0003, 16'h0023, 16'h0053,
		16'h000b, 16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b, 16'h002b,
		16'h0043, 16'h006b, 16'h004b};
	localparam logic [7:0] RST_ADDR [10] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'ha8, 8'he8,
		8'hb8, 8'hf8, 8'he9, 8'h55};

	fsia_arbiter fsia_arbiter_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext0_request_flag(ext0_request_flag),
		.ext1_request_flag(ext1_request_flag), .timer0_overflow_flag(timer0_overflow_flag),
		.timer1_overflow_flag(timer1_overflow_flag),
		.timer2_overflow_flag(timer2_overflow_flag),
		.timer2_external_flag(timer2_external_flag),
		.serial_receive_done(serial_receive_done),
		.serial_transmit_done(serial_transmit_done), .port_pins(port_pins),
		.core_irq_req(core_irq_req), .core_irq_vec(core_irq_vec),
		.core_irq_level(core_irq_level), .core_irq_ack(core_irq_ack),
		.core_irq_ret(core_irq_ret), .ext0_taken(tk[0]), .ext1_taken(tk[1]),
		.timer0_taken(tk[2]), .timer1_taken(tk[3]), .irq_o(irq_o));

	fsia_core_model fsia_core_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.core_irq_req(core_irq_req), .core_irq_vec(core_irq_vec),
		.core_irq_level(core_irq_level), .core_irq_ack(core_irq_ack),
		.core_irq_ret(core_irq_ret), .arm(1'b1), .ack_dly(8'h06), .svc_len(8'h1e),
		.last_vec(last_vec), .last_lvl(last_lvl), .n_taken(n_taken), .busy(busy));

	always #2 clk_sys = ~clk_sys;

	// each hardware clear pulse should appear once per taken vector of its source
	always @(posedge clk_sys)
	begin
		foreach (n_tk[i])
			if (tk[i] === 1'b1)
				n_tk[i]++;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHECK("register", e, reg_rdata)
	endtask

	task automatic take(input logic [15:0] v, input logic l);
		logic [7:0] start;
		int k;
		start = n_taken;
		k = 0;
		while (n_taken === start && k < 300)
		begin
			@(posedge clk_sys);
			k++;
		end
		#1;
		`CHECK("taken", start + 8'h01, n_taken)
		`CHECK("vector", v, last_vec)
		`CHECK("level", l, last_lvl)
	endtask

	task automatic wait_ret();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 300)
		begin
			@(posedge clk_sys);
			k++;
		end
	endtask

	// withdraw the request behind a vector, as its service routine would
	task automatic drop(input logic [15:0] v);
		int n;
		n = (v - 16'h003b) / 8;
		@(posedge clk_sys);
		case (v)
			16'h0003: ext0_request_flag <= 1'b0;
			16'h000b: timer0_overflow_flag <= 1'b0;
			16'h0013: ext1_request_flag <= 1'b0;
			16'h001b: timer1_overflow_flag <= 1'b0;
			16'h0023: {serial_receive_done, serial_transmit_done} <= 2'b00;
			16'h002b: {timer2_overflow_flag, timer2_external_flag} <= 2'b00;
			default:
			begin
				port_pins[n] <= 1'b1;
				repeat (4) @(posedge clk_sys);
				wr(8'hc0, ~port_pins);
			end
		endcase
	endtask

	initial
	begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (RST_ADDR[i]) rdchk(RST_ADDR[i], 8'h00);
		wr(8'h55, 8'hff);
		rdchk(8'h55, 8'h00);
		$display("test reset_values done");
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk_sys);
			port_pins <= ~(8'h01 << k);
			repeat (4) @(posedge clk_sys);
			port_pins <= 8'hff;
			repeat (4) @(posedge clk_sys);
			rdchk(8'hc0, 8'h01 << k);
			wr(8'hc0, 8'h00);
		end
		wr(8'he9, 8'hff);
		repeat (4) @(posedge clk_sys);
		rdchk(8'hc0, 8'hff);
		@(posedge clk_sys);
		port_pins <= 8'h00;
		repeat (4) @(posedge clk_sys);
		wr(8'hc0, 8'h00);
		rdchk(8'hc0, 8'h00);
		@(posedge clk_sys);
		port_pins <= 8'h08;
		repeat (4) @(posedge clk_sys);
		rdchk(8'hc0, 8'h08);
		@(posedge clk_sys);
		port_pins <= 8'hff;
		wr(8'he9, 8'h00);
		repeat (4) @(posedge clk_sys);
		wr(8'hc0, 8'h00);
		rdchk(8'hc0, 8'h00);
		$display("test port_flags done");
		wr(8'he8, 8'hff);
		wr(8'hf8, 8'h80);
		wr(8'ha8, 8'h3f);
		@(posedge clk_sys);
		{ext0_request_flag, ext1_request_flag, timer0_overflow_flag} <= 3'b111;
		{timer1_overflow_flag, serial_transmit_done, timer2_external_flag} <= 3'b111;
		port_pins <= 8'h00;
		repeat (8) @(posedge clk_sys);
		#1;
		`CHECK("core_irq_req", 1'b0, core_irq_req)
		wr(8'ha8, 8'hbf);
		for (int i = 0; i < 14; i++)
		begin
			take(ORDER[i], i == 0);
			drop(ORDER[i]);
			wait_ret();
		end
		@(posedge clk_sys);
		serial_receive_done <= 1'b1;
		take(16'h0023, 1'b0);
		drop(16'h0023);
		wait_ret();
		@(posedge clk_sys);
		timer2_overflow_flag <= 1'b1;
		take(16'h002b, 1'b0);
		drop(16'h002b);
		wait_ret();
		`CHECK("ext0_taken", 1, n_tk[0])
		`CHECK("ext1_taken", 1, n_tk[1])
		`CHECK("timer0_taken", 1, n_tk[2])
		`CHECK("timer1_taken", 1, n_tk[3])
		$display("test arbitration done");
		wr(8'hc1, 8'hff);
		@(posedge clk_sys);
		port_pins <= 8'hfe;
		take(16'h003b, 1'b0);
		@(posedge clk_sys);
		port_pins <= 8'hff;
		wait_ret();
		take(16'h003b, 1'b0);
		wr(8'hc0, 8'h00);
		wait_ret();
		rdchk(8'hc1, 8'h07);
		`CHECK("irq_o", 1'b0, irq_o)
		wr(8'hc2, 8'h04);
		repeat (3) @(posedge clk_sys);
		#1;
		`CHECK("irq_o", 1'b1, irq_o)
		wr(8'hc1, 8'h04);
		repeat (3) @(posedge clk_sys);
		#1;
		`CHECK("irq_o", 1'b0, irq_o)
		$display("test retrigger_events done");
		report_and_stop();
	end
endmodule
`default_nettype wire
